// *** design/acc_pkg.sv ***
// Constants shared by the comparator control block
package acc_pkg;

  localparam int          ADDR_W         = 12;
  localparam int          DATA_W         = 32;
  localparam int          REG_W          = 8;

  // Byte address of the only register
  localparam logic [11:0] CTRL_OFFSET    = 12'h000;
  localparam int          WORD_LSB       = 2;

  // Field positions
  localparam int          BIT_ENABLE     = 7;
  localparam int          BIT_REFSEL     = 6;
  localparam int          BIT_FLAG       = 5;
  localparam int          BIT_IE         = 4;
  localparam int          BIT_OUT        = 3;
  localparam int          BIT_PINEN      = 2;
  localparam int          MODE_LSB       = 0;
  localparam int          MODE_W         = 2;

  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic        BIT_RESET      = 1'b0;
  localparam logic [1:0]  MODE_RESET     = 2'h0;

  // Edge select encodings
  localparam logic [1:0]  MODE_FALL_A    = 2'h0;
  localparam logic [1:0]  MODE_RISE      = 2'h1;
  localparam logic [1:0]  MODE_FALL_B    = 2'h2;
  localparam logic [1:0]  MODE_BOTH      = 2'h3;

  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_DECERR    = 2'h3;

  // Run cycles before the edge detector trusts its history
  localparam logic [1:0]  SETTLE_DONE    = 2'h3;

endpackage : acc_pkg

// *** design/acc_edge_detect.sv ***
// Synchroniser and edge detector for the comparator output
`timescale 1ns/1ps
module acc_edge_detect
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic run,
  input  wire logic hold,
  input  wire logic async_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic       sync_a;
  logic       sync_b;
  logic       prev;
  logic [1:0] settle;
  wire        primed = (settle == acc_pkg::SETTLE_DONE);

  ////////////////////////////////////////////////////////////////////////
  // Two flops, then history; cleared while neither running nor held so a
  // fresh enable never sees a stale level as an edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn || (!run && !hold))
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev   <= 1'b0;
      settle <= 2'h0;
    end
    else if (!hold)
    begin
      sync_a <= async_in;
      sync_b <= sync_a;
      prev   <= sync_b;
      if (!primed)
        settle <= settle + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frozen while held: no edge can be reported then
  assign level = sync_b;
  assign rise  = primed && !hold && run && sync_b && !prev;
  assign fall  = primed && !hold && run && !sync_b && prev;

endmodule : acc_edge_detect

// *** design/acc_comparator_control.sv ***
// Analog comparator control: register, event logic, AXI4-Lite slave
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
module acc_comparator_control
#(
  parameter int ADDR_W = acc_pkg::ADDR_W
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              comparator_raw,
  input  wire logic              stop_light,
  input  wire logic              stop_deep,
  input  wire logic              capture_route_select,
  input  wire logic              timer_pin_in,
  output logic                   analog_enable,
  output logic                   reference_input_select,
  output logic                   event_irq,
  output logic                   timer_capture_in,
  output logic                   timer_pin_available
);

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a[ADDR_W-1:acc_pkg::WORD_LSB] ==
                acc_pkg::CTRL_OFFSET[ADDR_W-1:acc_pkg::WORD_LSB]);
  endfunction : addr_hit

  function automatic logic mode_hit(input logic [1:0] mode,
                                    input logic       rise,
                                    input logic       fall);
    mode_hit = 1'b0;
    case (mode)
      acc_pkg::MODE_RISE:  mode_hit = rise;
      acc_pkg::MODE_BOTH:  mode_hit = rise || fall;
      default:             mode_hit = fall;
    endcase
  endfunction : mode_hit

  ////////////////////////////////////////////////////////////////////////
  // Register fields
  logic       comparator_module_enable;
  logic       compare_event_flag;
  logic       event_interrupt_enable;
  logic [1:0] event_edge_select;
  logic       comparator_output_value;
  logic       cmp_rise;
  logic       cmp_fall;

  // Bus holding state
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic              w_lane0_q;

  ////////////////////////////////////////////////////////////////////////
  // Event path
  wire stop_any  = stop_light || stop_deep;
  wire cmp_run   = comparator_module_enable && !stop_any;
  wire cmp_event = mode_hit(event_edge_select, cmp_rise, cmp_fall);

  // Core output is high when non-inverting input is above
  acc_edge_detect u_edge
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (cmp_run),
    .hold     (stop_light),
    .async_in (comparator_raw),
    .level    (comparator_output_value),
    .rise     (cmp_rise),
    .fall     (cmp_fall)
  );

  ////////////////////////////////////////////////////////////////////////
  // Write channel
  wire write_go = aw_held && w_held && !bvalid;
  wire write_ok = addr_hit(aw_addr_q);
  // Clocks are halted in light stop, so software cannot change state
  wire reg_we   = write_go && write_ok && w_lane0_q && !stop_any;
  wire flag_clr = reg_we && w_data_q[acc_pkg::BIT_FLAG];

  assign awready = !aw_held;
  assign wready  = !w_held;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= 32'h0000_0000;
      w_lane0_q <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_held   <= 1'b1;
        aw_addr_q <= awaddr;
      end
      else if (write_go)
        aw_held <= 1'b0;
      if (wvalid && wready)
      begin
        w_held    <= 1'b1;
        w_data_q  <= wdata;
        w_lane0_q <= wstrb[0];
      end
      else if (write_go)
        w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= acc_pkg::RESP_OKAY;
    end
    else if (write_go)
    begin
      bvalid <= 1'b1;
      bresp  <= write_ok ? acc_pkg::RESP_OKAY : acc_pkg::RESP_DECERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Control bits; deep stop returns them to reset, light stop
  // keeps them (resume on interrupt wake)
  always_ff @(posedge aclk)
  begin
    if (!aresetn || stop_deep)
    begin
      comparator_module_enable <= acc_pkg::BIT_RESET;
      reference_input_select   <= acc_pkg::BIT_RESET;
      event_interrupt_enable   <= acc_pkg::BIT_RESET;
      event_edge_select        <= acc_pkg::MODE_RESET;
    end
    else if (reg_we)
    begin
      comparator_module_enable <= w_data_q[acc_pkg::BIT_ENABLE];
      reference_input_select   <= w_data_q[acc_pkg::BIT_REFSEL];
      event_interrupt_enable   <= w_data_q[acc_pkg::BIT_IE];
      event_edge_select        <=
        w_data_q[acc_pkg::MODE_LSB +: acc_pkg::MODE_W];
    end
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn || stop_deep)
      compare_event_flag <= acc_pkg::BIT_RESET;
    else if (cmp_event)
      compare_event_flag <= 1'b1;
    else if (flag_clr)
      compare_event_flag <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel; the single 8-bit register sits in the low byte
  wire [7:0] status_image =
    {comparator_module_enable, reference_input_select,
     compare_event_flag, event_interrupt_enable,
     comparator_output_value, 1'b0,
     event_edge_select};

  assign arready = !rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= acc_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata  <= addr_hit(araddr) ? {24'h00_0000, status_image}
                                 : 32'h0000_0000;
      rresp  <= addr_hit(araddr) ? acc_pkg::RESP_OKAY
                                 : acc_pkg::RESP_DECERR;
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs; light stop leaves event_irq ungated, so the interrupt can wake; deep stop clears its flag and enable
  assign analog_enable       = cmp_run;
  assign event_irq           = compare_event_flag &&
                               event_interrupt_enable;
  assign timer_capture_in    = capture_route_select ?
                               comparator_output_value : timer_pin_in;
  assign timer_pin_available = !capture_route_select;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_disabled_quiet;
    !comparator_module_enable |-> !cmp_event;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("event while comparator disabled");

  property p_refsel_write;
    reg_we |=> reference_input_select == $past(w_data_q[6]);
  endproperty
  a_refsel_write: assert property (p_refsel_write)
    else $error("reference select not written");

  property p_event_sets;
    cmp_event && !stop_deep |=> compare_event_flag;
  endproperty
  a_event_sets: assert property (p_event_sets)
    else $error("event did not set flag");

  property p_zero_keeps;
    compare_event_flag && reg_we && !w_data_q[5] |=> compare_event_flag;
  endproperty
  a_zero_keeps: assert property (p_zero_keeps)
    else $error("writing zero cleared flag");

  property p_one_clears;
    flag_clr && !cmp_event && !stop_deep |=> !compare_event_flag;
  endproperty
  a_one_clears: assert property (p_one_clears)
    else $error("writing one did not clear flag");

  property p_irq;
    cmp_event && event_interrupt_enable && !reg_we |=> event_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt does not follow flag and enable");

  property p_out_off;
    !comparator_module_enable && !stop_light ##1
      !comparator_module_enable |-> !comparator_output_value;
  endproperty
  a_out_off: assert property (p_out_off)
    else $error("output bit set while disabled");

  property p_reserved;
    rvalid |-> !rdata[acc_pkg::BIT_PINEN];
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bit reads one");

  property p_rise_only;
    cmp_event && event_edge_select == 2'h1 |-> cmp_rise && !cmp_fall;
  endproperty
  a_rise_only: assert property (p_rise_only)
    else $error("rising mode fired on non-rising edge");

  property p_stop_off;
    stop_any |-> !analog_enable && !cmp_event;
  endproperty
  a_stop_off: assert property (p_stop_off)
    else $error("comparator active in stop");

  property p_deep_reset;
    stop_deep |=> !comparator_module_enable && !compare_event_flag &&
                  event_edge_select == 2'h0 && !event_interrupt_enable;
  endproperty
  a_deep_reset: assert property (p_deep_reset)
    else $error("deep stop did not reset register");

  property p_light_keep;
    stop_light && !stop_deep |=> $stable(event_edge_select) &&
      $stable(comparator_module_enable) && $stable(compare_event_flag);
  endproperty
  a_light_keep: assert property (p_light_keep)
    else $error("register changed in light stop");

  property p_set_wins;
    cmp_event && flag_clr |=> compare_event_flag;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat a same-cycle event");

  property p_route;
    capture_route_select |-> timer_capture_in == comparator_output_value
                             && !timer_pin_available;
  endproperty
  a_route: assert property (p_route)
    else $error("capture routing wrong");

  property p_bresp_time;
    write_go |=> bvalid;
  endproperty
  a_bresp_time: assert property (p_bresp_time)
    else $error("write response late");

  c_event_irq: cover property (cmp_event && event_interrupt_enable);
  c_set_wins:  cover property (cmp_event && flag_clr);
  c_both_mode: cover property (cmp_fall && event_edge_select == 2'h3
                               ##[1:50] cmp_rise);
  c_light:     cover property (stop_light ##1 !stop_light);

endmodule : acc_comparator_control

// *** test/acc_core_model.sv ***
// Behavioural model of the analog comparator core
`timescale 1ns/1ps
module acc_core_model
#(
  parameter logic [7:0] BANDGAP = 8'h80
)
(
  input  wire logic       aclk,
  input  wire logic       analog_enable,
  input  wire logic       reference_input_select,
  input  wire logic [7:0] positive_input_pin,
  input  wire logic [7:0] negative_input_pin,
  output logic            comparator_raw
);
  logic [7:0] plus_v;
  logic       idle_out = 1'b0;

  assign plus_v = reference_input_select ? BANDGAP
                                         : positive_input_pin;
  // Unpowered core gives no valid level, so keep it moving
  always_ff @(posedge aclk)
    idle_out <= !idle_out;
  assign comparator_raw = analog_enable
    ? (plus_v > negative_input_pin) : idle_out;
endmodule : acc_core_model

// *** test/tb_acc_comparator_control.sv ***
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
module tb_acc_comparator_control;
  localparam logic [7:0] BG = 8'h80;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, arready, bvalid, rvalid, event_irq;
  logic        comparator_raw, stop_light, stop_deep, timer_pin_in;
  logic        capture_route_select, analog_enable, timer_capture_in;
  logic        reference_input_select, timer_pin_available;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_w;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, bs_v, rs_v;
  logic [7:0]  pos_v, neg_v, ctl, ex;
  int          n_errors, compares, seed, i, m;

  acc_comparator_control uut
  (
    .aclk                   (aclk),
    .aresetn                (aresetn),
    .awaddr                 (awaddr),
    .awvalid                (awvalid),
    .awready                (awready),
    .wdata                  (wdata),
    .wstrb                  (wstrb),
    .wvalid                 (wvalid),
    .wready                 (wready),
    .bresp                  (bresp),
    .bvalid                 (bvalid),
    .bready                 (bready),
    .araddr                 (araddr),
    .arvalid                (arvalid),
    .arready                (arready),
    .rdata                  (rdata),
    .rresp                  (rresp),
    .rvalid                 (rvalid),
    .rready                 (rready),
    .comparator_raw         (comparator_raw),
    .stop_light             (stop_light),
    .stop_deep              (stop_deep),
    .capture_route_select   (capture_route_select),
    .timer_pin_in           (timer_pin_in),
    .analog_enable          (analog_enable),
    .reference_input_select (reference_input_select),
    .event_irq              (event_irq),
    .timer_capture_in       (timer_capture_in),
    .timer_pin_available    (timer_pin_available)
  );
  acc_core_model #(.BANDGAP(BG)) core
  (
    .aclk                   (aclk),
    .analog_enable          (analog_enable),
    .reference_input_select (reference_input_select),
    .positive_input_pin     (pos_v),
    .negative_input_pin     (neg_v),
    .comparator_raw         (comparator_raw)
  );

  ////////////////////////////////////////
  function automatic logic [7:0] exp_reg(input logic [7:0] c,
                                         input logic f);
    logic lv;
    lv = c[7] & ((c[6] ? BG : pos_v) > neg_v);
    return (c & 8'hd3) | {2'b00, f, 1'b0, lv, 3'b000};
  endfunction : exp_reg

  task automatic print_verdict();
    if (n_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  task automatic hung();
    n_errors++;
    print_verdict();
  endtask : hung

  // Samples at the falling edge: readies are combinational
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic ta, tw, t;
    t = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int n = 0; n < 40 && !t; n++)
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      t = bvalid;
      bs_v = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!t) hung();
  endtask : wr

  task automatic rd(input logic [11:0] a);
    logic ta, t;
    t = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int n = 0; n < 40 && !t; n++)
    begin
      @(negedge aclk);
      ta = arvalid && arready;
      t = rvalid;
      rd_w = rdata;
      rs_v = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!t) hung();
  endtask : rd

  ////////////////////////////////////////
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial
  begin
    seed = 32'h3e6c8f9b;
    n_errors = 0;
    compares = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {stop_light, stop_deep, capture_route_select} = 3'h0;
    timer_pin_in = 1'b0;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'hf;
    pos_v = 8'h40;
    neg_v = 8'h80;
    tick(3);
    aresetn <= 1'b1;
    rd(12'h000);
    chk("reset", rd_w, 32'h0);
    wr(12'h008, 8'hff);
    chk("bresp", 32'(bs_v), 32'(acc_pkg::RESP_DECERR));
    rd(12'h004);
    chk("rresp", 32'(rs_v), 32'(acc_pkg::RESP_DECERR));
    rd(12'h000);
    chk("unmapped", rd_w, 32'h0);
    for (m = 0; m < 4; m++)
    begin
      ctl = 8'h90 | 8'(m);
      wr(12'h000, ctl | 8'h20);
      tick(10);
      pos_v <= 8'hc0;
      tick(8);
      rd(12'h000);
      chk("rise", rd_w, 32'(exp_reg(ctl, m[0])));
      chk("irq", 32'(event_irq), 32'(m[0]));
      wr(12'h000, ctl | 8'h20);
      pos_v <= 8'h40;
      tick(8);
      rd(12'h000);
      chk("fall", rd_w, 32'(exp_reg(ctl, m != 1)));
      wr(12'h000, ctl);
      rd(12'h000);
      chk("w0", rd_w, 32'(exp_reg(ctl, m != 1)));
      wr(12'h000, ctl | 8'h20);
      rd(12'h000);
      chk("w1c", rd_w, 32'(exp_reg(ctl, 1'b0)));
    end
    wr(12'h000, 8'h83);
    pos_v <= 8'hc0;
    tick(8);
    chk("mask", 32'(event_irq), 32'h0);
    neg_v <= 8'h70;
    wr(12'h000, 8'he3);
    tick(8);
    neg_v <= 8'h90;
    tick(8);
    rd(12'h000);
    chk("bandgap", rd_w, 32'(exp_reg(8'hc3, 1'b1)));
    chk("refsel", 32'(reference_input_select), 32'h1);
    pos_v <= 8'h40;
    neg_v <= 8'h80;
    wr(12'h000, 8'h33);
    tick(10);
    rd(12'h000);
    chk("off", rd_w, 32'(exp_reg(8'h13, 1'b0)));
    chk("offirq", 32'(event_irq), 32'h0);
    wr(12'h000, 8'hb3);
    tick(10);
    stop_light <= 1'b1;
    tick(2);
    chk("stop_on", 32'(analog_enable), 32'h0);
    wr(12'h000, 8'h00);
    pos_v <= 8'hc0;
    tick(5);
    pos_v <= 8'h40;
    tick(2);
    stop_light <= 1'b0;
    tick(8);
    rd(12'h000);
    chk("light", rd_w, 32'(exp_reg(8'h93, 1'b0)));
    // Rise lands in the very cycle the one-to-clear write is applied
    pos_v <= 8'hc0;
    wr(12'h000, 8'hb3);
    rd(12'h000);
    chk("setwins", rd_w, 32'(exp_reg(8'h93, 1'b1)));
    chk("setirq", 32'(event_irq), 32'h1);
    stop_deep <= 1'b1;
    tick(3);
    stop_deep <= 1'b0;
    rd(12'h000);
    chk("deep", rd_w, 32'h0);
    wr(12'h000, 8'hd3);
    aresetn <= 1'b0;
    tick(3);
    aresetn <= 1'b1;
    rd(12'h000);
    chk("rst", rd_w, 32'h0);
    wstrb <= 4'he;
    wr(12'h000, 8'h93);
    wstrb <= 4'hf;
    rd(12'h000);
    chk("strobe", rd_w, 32'h0);
    for (i = 0; i < 12; i++)
    begin
      wr(12'h000, 8'h00);
      pos_v <= 8'($random(seed));
      neg_v <= 8'($random(seed));
      capture_route_select <= 1'($random(seed));
      timer_pin_in <= 1'($random(seed));
      ctl = 8'($random(seed)) | 8'h20;
      wr(12'h000, ctl);
      tick(8);
      rd(12'h000);
      ex = exp_reg(ctl, 1'b0);
      chk("rand", rd_w, 32'(ex));
      if (!capture_route_select || ctl[7])
        chk("cap", 32'(timer_capture_in), 32'(capture_route_select
          ? ex[3] : timer_pin_in));
      chk("avail", 32'(timer_pin_available),
        32'(!capture_route_select));
    end
    print_verdict();
  end
endmodule : tb_acc_comparator_control
